// >>> core/tid_pkg.sv
/*
  Constants and carrier types for the topology identifier decoder.
  Assumes a 32-bit APB register bus and one 40 MHz clock.
*/
package tid_pkg;
  localparam logic [11:0] ADDR_ID       = 12'h000;
  localparam logic [11:0] ADDR_MAXLP    = 12'h004;
  localparam logic [11:0] ADDR_CORES    = 12'h008;
  localparam logic [11:0] ADDR_CACHE    = 12'h00C;
  localparam logic [11:0] ADDR_CTRL     = 12'h010;
  localparam logic [11:0] ADDR_THREAD   = 12'h014;
  localparam logic [11:0] ADDR_CORE     = 12'h018;
  localparam logic [11:0] ADDR_PACKAGE  = 12'h01C;
  localparam logic [11:0] ADDR_WIDTHS   = 12'h020;
  localparam logic [11:0] ADDR_LEAF1B   = 12'h024;
  localparam logic [11:0] ADDR_LEAF4A   = 12'h028;
  localparam logic [11:0] ADDR_LEAF1D   = 12'h02C;

  localparam int ID_LSB     = 24;
  localparam int LP_LSB     = 16;
  localparam int CORES_LSB  = 26;
  localparam int CACHE_LSB  = 14;
  localparam int CACHE_MSB  = 25;
  localparam int MT_BIT     = 28;
  localparam int CTRL_MT    = 0;
  localparam int CTRL_LEAF4 = 1;
  localparam int CTRL_GO    = 2;

  localparam logic [31:0] ID_MASK    = 32'hFF000000;
  localparam logic [31:0] LP_MASK    = 32'h00FF0000;
  localparam logic [7:0]  FULL_MASK  = 8'hFF;
  localparam logic [7:0]  ONE8       = 8'h01;
  localparam logic [7:0]  ID_RESET   = 8'h00;
  localparam logic [7:0]  LP_RESET   = 8'h01;
  localparam logic [5:0]  CORE_RESET = 6'h00;
  localparam logic [11:0] CACHE_RST  = 12'h000;
  localparam logic [2:0]  CTRL_RESET = 3'h0;

  typedef struct packed {
    logic [7:0] threadIdx;
    logic [7:0] coreIdx;
    logic [7:0] packageIdx;
  } tid_ids_s;

  typedef struct packed {
    logic [3:0] threadW;
    logic [3:0] coreW;
    logic [3:0] packageShift;
  } tid_widths_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CALC  = 2'b01,
    ST_DONE  = 2'b11
  } tid_state_e;
endpackage : tid_pkg

// >>> core/tid_subfield_extract.sv
/*
  Width calculation and sub-field masking for one identifier level.
  Assumes an 8-bit identifier and combinational use by its parent.
*/
`timescale 1ns/100ps
`default_nettype none
module tid_subfield_extract (
  input  wire logic [7:0] fullId,
  input  wire logic [7:0] maxCount,
  input  wire logic [3:0] shiftCount,
  output logic      [3:0] width,
  output logic      [7:0] subId
);
  logic [7:0] countLess;
  logic [7:0] mask;
  logic [8:0] hiMask;
  logic [8:0] loMask;

  // Highest set bit of count minus one, plus one; zero for one
  always_comb begin
    countLess = maxCount - tid_pkg::ONE8;
    width = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (countLess[i]) begin
        width = 4'(i + 1);
      end
    end
  end

  // Mask from shift up to shift plus width minus one, no shift down
  always_comb begin
    loMask = {1'b0, tid_pkg::FULL_MASK} << shiftCount;
    hiMask = {1'b0, tid_pkg::FULL_MASK} << (5'(shiftCount) + 5'(width));
    mask   = loMask[7:0] ^ hiMask[7:0];
    subId  = fullId & mask;
  end
endmodule : tid_subfield_extract
`default_nettype wire

// >>> core/tid_topology_decoder.sv
/*
  Topology identifier decoder: holds reported identification fields,
  decodes the identifier into thread, core and package indices.
  Assumes an APB master on the same clock; no interrupts, no buffering.
*/
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module tid_topology_decoder (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  output logic      [7:0]  threadIndex,
  output logic      [7:0]  coreIndex,
  output logic      [7:0]  packageIndex,
  output logic             primaryThread,
  output logic             decodeValid
);
  // Software-visible identification fields
  logic [7:0]  initialId;
  logic [7:0]  maxLp;
  logic [5:0]  coresField;
  logic [11:0] cacheShare;
  logic [2:0]  ctrl;
  logic [7:0]  next_initialId;
  logic [7:0]  next_maxLp;
  logic [5:0]  next_coresField;
  logic [11:0] next_cacheShare;
  logic [2:0]  next_ctrl;

  tid_pkg::tid_ids_s    ids;
  tid_pkg::tid_ids_s    next_ids;
  tid_pkg::tid_widths_s widths;
  tid_pkg::tid_widths_s next_widths;
  tid_pkg::tid_state_e  state;
  tid_pkg::tid_state_e  next_state;
  logic [31:0]          rdata;
  logic [31:0]          next_rdata;
  logic                 rdErr;
  logic                 next_rdErr;

  logic       wrEn;
  logic       rdEn;
  logic [7:0] effLp;
  logic [7:0] effCores;
  logic [7:0] lpPerCore;
  logic [3:0] threadW;
  logic [3:0] coreW;
  logic [3:0] lpW;
  logic [7:0] threadSub;
  logic [7:0] coreSub;
  logic [7:0] pkgMask;
  logic [31:0] leaf1b;
  logic [31:0] leaf4a;
  logic [31:0] leaf1d;

  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~pwrite & rdErr;
  assign prdata  = rdata;

  // Identification words assembled from held fields
  always_comb begin
    leaf1b = 32'h00000000;
    leaf1b[tid_pkg::ID_LSB +: 8] = initialId;
    leaf1b[tid_pkg::LP_LSB +: 8] = maxLp;
    leaf4a = 32'h00000000;
    leaf4a[tid_pkg::CORES_LSB +: 6] = coresField;
    leaf4a[tid_pkg::CACHE_MSB:tid_pkg::CACHE_LSB] = cacheShare;
    leaf1d = 32'h00000000;
    leaf1d[tid_pkg::MT_BIT] = ctrl[tid_pkg::CTRL_MT];
  end
  // Effective counts; both one without capability, core count one without leaf 4
  always_comb begin
    if (!ctrl[tid_pkg::CTRL_MT]) begin
      effLp    = tid_pkg::ONE8;
      effCores = tid_pkg::ONE8;
    end else begin
      effLp    = (maxLp == 8'h00) ? tid_pkg::ONE8 : maxLp;
      effCores = ctrl[tid_pkg::CTRL_LEAF4] ? (8'(coresField) + tid_pkg::ONE8)
                                           : tid_pkg::ONE8;
    end
    lpPerCore = (effLp / effCores == 8'h00) ? tid_pkg::ONE8 : effLp / effCores;
  end

  // Thread field at shift zero
  tid_subfield_extract uThread (
    .fullId     (initialId),
    .maxCount   (lpPerCore),
    .shiftCount (4'h0),
    .width      (threadW),
    .subId      (threadSub)
  );

  // Core field shifted by thread width, from run-time counts
  tid_subfield_extract uCore (
    .fullId     (initialId),
    .maxCount   (effCores),
    .shiftCount (threadW),
    .width      (coreW),
    .subId      (coreSub)
  );

  // Width only used for the package shift
  tid_subfield_extract uPkg (
    .fullId     (initialId),
    .maxCount   (effLp),
    .shiftCount (4'h0),
    .width      (lpW),
    .subId      ()
  );

  assign pkgMask = tid_pkg::FULL_MASK << lpW;

  // Register writes
  always_comb begin
    next_initialId  = initialId;
    next_maxLp      = maxLp;
    next_coresField = coresField;
    next_cacheShare = cacheShare;
    next_ctrl       = ctrl;
    next_ctrl[tid_pkg::CTRL_GO] = 1'b0;
    if (wrEn) begin
      case (paddr)
        tid_pkg::ADDR_ID:    next_initialId  = pwdata[7:0];
        tid_pkg::ADDR_MAXLP: next_maxLp      = pwdata[7:0];
        tid_pkg::ADDR_CORES: next_coresField = pwdata[5:0];
        tid_pkg::ADDR_CACHE: next_cacheShare = pwdata[11:0];
        tid_pkg::ADDR_CTRL:  next_ctrl       = pwdata[2:0];
        tid_pkg::ADDR_LEAF1B: begin
          next_initialId = 8'((pwdata & tid_pkg::ID_MASK) >> tid_pkg::ID_LSB);
          next_maxLp     = 8'((pwdata & tid_pkg::LP_MASK) >> tid_pkg::LP_LSB);
        end
        tid_pkg::ADDR_LEAF4A: begin
          next_coresField = pwdata[31:tid_pkg::CORES_LSB];
          next_cacheShare = pwdata[tid_pkg::CACHE_MSB:tid_pkg::CACHE_LSB];
        end
        tid_pkg::ADDR_LEAF1D: next_ctrl[tid_pkg::CTRL_MT] = pwdata[tid_pkg::MT_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      initialId  <= tid_pkg::ID_RESET;
      maxLp      <= tid_pkg::LP_RESET;
      coresField <= tid_pkg::CORE_RESET;
      cacheShare <= tid_pkg::CACHE_RST;
      ctrl       <= tid_pkg::CTRL_RESET;
    end else begin
      initialId  <= next_initialId;
      maxLp      <= next_maxLp;
      coresField <= next_coresField;
      cacheShare <= next_cacheShare;
      ctrl       <= next_ctrl;
    end
  end

  // Decode sequencing; outputs follow inputs by one cycle
  always_comb begin
    next_state  = state;
    next_ids    = ids;
    next_widths = widths;
    case (state)
      tid_pkg::ST_IDLE: begin
        if (next_ctrl[tid_pkg::CTRL_GO] || wrEn) begin
          next_state = tid_pkg::ST_CALC;
        end
      end
      tid_pkg::ST_CALC: next_state = tid_pkg::ST_DONE;
      tid_pkg::ST_DONE: begin
        if (wrEn) begin
          next_state = tid_pkg::ST_CALC;
        end
      end
      default: next_state = tid_pkg::ST_IDLE;
    endcase
    if (state != tid_pkg::ST_IDLE) begin
      next_ids.threadIdx  = threadSub;
      next_ids.coreIdx    = coreSub;
      next_ids.packageIdx = initialId & pkgMask;
      next_widths.threadW = threadW;
      next_widths.coreW   = coreW;
      next_widths.packageShift = lpW;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= tid_pkg::ST_IDLE;
      ids    <= '0;
      widths <= '0;
    end else begin
      state  <= next_state;
      ids    <= next_ids;
      widths <= next_widths;
    end
  end

  assign threadIndex   = ids.threadIdx;
  assign coreIndex     = ids.coreIdx;
  assign packageIndex  = ids.packageIdx;
  assign primaryThread = (ids.threadIdx == 8'h00);
  assign decodeValid   = (state == tid_pkg::ST_DONE);

  // Read data captured in setup cycle
  always_comb begin
    next_rdata = rdata;
    next_rdErr = rdErr;
    if (rdEn) begin
      next_rdata = 32'h00000000;
      next_rdErr = 1'b0;
      case (paddr)
        tid_pkg::ADDR_ID:      next_rdata[7:0]  = initialId;
        tid_pkg::ADDR_MAXLP:   next_rdata[7:0]  = maxLp;
        tid_pkg::ADDR_CORES:   next_rdata[5:0]  = coresField;
        tid_pkg::ADDR_CACHE:   next_rdata[11:0] = cacheShare;
        tid_pkg::ADDR_CTRL:    next_rdata[2:0]  = ctrl;
        tid_pkg::ADDR_THREAD:  next_rdata[7:0]  = ids.threadIdx;
        tid_pkg::ADDR_CORE:    next_rdata[7:0]  = ids.coreIdx;
        tid_pkg::ADDR_PACKAGE: next_rdata[7:0]  = ids.packageIdx;
        tid_pkg::ADDR_WIDTHS:  next_rdata[11:0] = widths;
        tid_pkg::ADDR_LEAF1B:  next_rdata       = leaf1b;
        tid_pkg::ADDR_LEAF4A:  next_rdata       = leaf4a;
        tid_pkg::ADDR_LEAF1D:  next_rdata       = leaf1d;
        default:               next_rdErr       = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h00000000;
      rdErr <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rdErr <= next_rdErr;
    end
  end
endmodule : tid_topology_decoder
`default_nettype wire

// >>> test/tid_decoder_asserts.sv
/*
  Port checker for the topology identifier decoder.
  Assumes it is bound to tid_topology_decoder on one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tid_decoder_asserts (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  threadIndex,
  input wire logic [7:0]  coreIndex,
  input wire logic [7:0]  packageIndex,
  input wire logic        primaryThread,
  input wire logic        decodeValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic wr;
  assign wr = psel && penable && pwrite;
  // Reset seen at the previous edge; false at the first edge
  logic inReset = 1'b0;
  always @(posedge clk) begin
    inReset <= !arst_n;
  end
  // Recompute: one busy cycle, then valid
  sequence s_recalc;
    !decodeValid ##1 decodeValid;
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_unmapped_err: assert property (
    psel && penable && !pwrite && paddr > 12'h02C |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped read not refused");
  chk_mapped_ok: assert property (
    psel && penable && (pwrite || paddr <= 12'h02C) |-> !pslverr)
    else $error("spurious slave error");
  chk_primary_flag: assert property (primaryThread == (threadIndex == 8'h00))
    else $error("primary flag wrong");
  chk_write_recalc: assert property (wr && paddr <= 12'h010 |=> s_recalc)
    else $error("no recompute after write");
  chk_index_hold: assert property (
    decodeValid && !wr |=> $stable({threadIndex, coreIndex, packageIndex}))
    else $error("indices moved without write");
  chk_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
    !arst_n && inReset |-> {threadIndex, coreIndex, packageIndex} == 24'h000000 && !decodeValid)
    else $error("indices not cleared in reset");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  chk_fields_apart: assert property (
    ((threadIndex & coreIndex) | (threadIndex & packageIndex)) == 8'h00)
    else $error("sub-fields overlap");
endmodule : tid_decoder_asserts

bind tid_topology_decoder tid_decoder_asserts i_tid_decoder_asserts (
  .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .prdata, .threadIndex, .coreIndex, .packageIndex, .primaryThread, .decodeValid);
`default_nettype wire

// >>> test/tid_topology_decoder_bench.sv
/*
  Self-checking bench for the topology identifier decoder.
  Assumes the zero-wait APB map and decode timing of the hand-over.
*/
`timescale 1ns/100ps
`default_nettype none
module tid_topology_decoder_bench;
  logic        clk     = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [7:0]  threadIndex;
  logic [7:0]  coreIndex;
  logic [7:0]  packageIndex;
  logic        primaryThread;
  logic        decodeValid;
  logic [31:0] rdVal;
  logic        rdErr;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          cycles     = 0;

  always #12.5 clk = ~clk;

  tid_topology_decoder i_tid_topology_decoder (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .threadIndex, .coreIndex, .packageIndex, .primaryThread, .decodeValid);

  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check32

  task automatic check1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : check1

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdVal   = prdata;
    rdErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
    apb(1'b0, addr, 32'h00000000);
    check32(rdVal, exp);
    check1(rdErr, expErr);
  endtask : rd

  // Load identifier and count through leaf 1 word, junk in low bits
  task automatic decode(input logic [7:0] id, input logic [7:0] lp, input logic [23:0] exp);
    int i;
    i = 0;
    apb(1'b1, tid_pkg::ADDR_LEAF1B, {id, lp, 16'hFFFF});
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (decodeValid !== 1'b1 && i < 8);
    check1(decodeValid, 1'b1);
    check32({8'h00, threadIndex, coreIndex, packageIndex}, {8'h00, exp});
    check1(primaryThread, exp[23:16] == 8'h00);
  endtask : decode

  task automatic test_no_mt();
    decode(8'h5A, 8'h08, 24'h00005A);
    rd(tid_pkg::ADDR_ID, 32'h0000005A, 1'b0);
    rd(tid_pkg::ADDR_MAXLP, 32'h00000008, 1'b0);
    $display("test_no_mt done");
  endtask : test_no_mt

  task automatic test_table_one();
    int id;
    apb(1'b1, tid_pkg::ADDR_CTRL, 32'h00000001);
    for (id = 0; id < 8; id++) begin
      decode(id[7:0], 8'h02, {id[7:0] & 8'h01, 8'h00, id[7:0] & 8'hFE});
    end
    $display("test_table_one done");
  endtask : test_table_one

  task automatic test_table_two();
    int id;
    apb(1'b1, tid_pkg::ADDR_CTRL, 32'h00000003);
    apb(1'b1, tid_pkg::ADDR_LEAF4A, 32'h04000000);
    rd(tid_pkg::ADDR_CORES, 32'h00000001, 1'b0);
    for (id = 0; id < 8; id++) begin
      decode(id[7:0], 8'h04, {id[7:0] & 8'h01, id[7:0] & 8'h02, id[7:0] & 8'h04});
    end
    rd(tid_pkg::ADDR_WIDTHS, 32'h00000112, 1'b0);
    $display("test_table_two done");
  endtask : test_table_two

  task automatic test_odd_counts();
    apb(1'b1, tid_pkg::ADDR_LEAF4A, 32'h0AAF0000);
    rd(tid_pkg::ADDR_CACHE, 32'h00000ABC, 1'b0);
    decode(8'hFF, 8'h06, 24'h0106F8);
    rd(tid_pkg::ADDR_WIDTHS, 32'h00000123, 1'b0);
    rd(12'h030, 32'h00000000, 1'b1);
    apb(1'b1, 12'h030, 32'hFFFFFFFF);
    check1(rdErr, 1'b0);
    rd(tid_pkg::ADDR_ID, 32'h000000FF, 1'b0);
    $display("test_odd_counts done");
  endtask : test_odd_counts

  // Reset in mid-run clears indices and fields
  task automatic test_mid_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    check32({8'h00, threadIndex, coreIndex, packageIndex}, 32'h00000000);
    check1(decodeValid, 1'b0);
    arst_n <= 1'b1;
    rd(tid_pkg::ADDR_ID, 32'h00000000, 1'b0);
    rd(tid_pkg::ADDR_CTRL, 32'h00000000, 1'b0);
    $display("test_mid_reset done");
  endtask : test_mid_reset

  initial begin
    repeat (16) @(posedge clk);
    check32({8'h00, threadIndex, coreIndex, packageIndex}, 32'h00000000);
    check1(primaryThread, 1'b1);
    arst_n <= 1'b1;
    rd(tid_pkg::ADDR_MAXLP, 32'h00000001, 1'b0);
    rd(tid_pkg::ADDR_CTRL, 32'h00000000, 1'b0);
    $display("test_reset done");
    test_no_mt();
    test_table_one();
    test_table_two();
    test_odd_counts();
    test_mid_reset();
    stop_test();
  end
endmodule : tid_topology_decoder_bench
`default_nettype wire
